// >>> src/pcrc_ctrl.sv
// Controller that loads and reads the configuration word of an asynchronous
// pseudo-static memory and steers its low-power modes through the sleep pin.
// Assumes the memory pins are sampled on i_ref_clk and the bus is APB.
//
// Contract
// - Reserved configuration bits 18..8 and 3 are always written as zero.
// - Change deep sleep only by pin-initiated load, never by software sequence.
// - After deep sleep ends, no normal access for 150 us.
// - Temperature code must be at or above the case temperature.
// - Low-power mode needs the pin low longer than 10 us; high leaves it.
// - Write after the pin falls latches address lines into the word.
// - Software sequence uses address 7FFFFh for all four operations.
`timescale 1ns/100ps
`default_nettype none
module pcrc_ctrl
    import pcrc_pkg::*;
(
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // APB slave.
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Memory control pins, all active low.
    output logic o_sleep_control_pin_n,
    output logic o_ce_n,
    output logic o_we_n,
    output logic o_oe_n,
    output logic [1:0] o_byte_n,
    // Memory address and data.
    output logic [AW-1:0] o_addr,
    input wire logic [DW-1:0] i_dq,
    output logic [DW-1:0] o_dq,
    output logic o_dq_oe
);
    typedef enum logic [2:0] {
        SQ_PIN, SQ_SW_WR, SQ_SW_RD, SQ_MEM_WR, SQ_MEM_RD
    } pcrc_seq_t;

    typedef enum logic [2:0] {
        S_IDLE, S_ZZ_PRE, S_SETUP, S_STROBE, S_HOLD, S_ZZ_POST, S_SLEEP, S_INIT
    } pcrc_state_t;

    localparam logic [TIMER_W-1:0] T_STROBE = TIMER_W'(STROBE_CYC - 1);
    localparam logic [TIMER_W-1:0] T_SLEEP = TIMER_W'(SLEEP_CYC - 1);
    // The pin rises one cycle after the state change, so the wait runs one longer.
    localparam logic [TIMER_W-1:0] T_INIT = TIMER_W'(INIT_CYC);
    localparam logic [1:0] STEP_SELECT = 2'h2;
    localparam logic [1:0] STEP_LAST_SW = 2'h3;

    pcrc_ctl_if ctl ();

    pcrc_apb_regs u_regs (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_psel(i_psel),
        .i_penable(i_penable),
        .i_pwrite(i_pwrite),
        .i_paddr(i_paddr),
        .i_pwdata(i_pwdata),
        .o_prdata(o_prdata),
        .o_pready(o_pready),
        .o_pslverr(o_pslverr),
        .ctl(ctl.regs)
    );

    // Which steps of a sequence drive the data bus.
    function automatic logic step_writes(input pcrc_seq_t sq, input logic [1:0] st);
        unique case (sq)
            SQ_PIN, SQ_MEM_WR: return 1'b1;
            SQ_MEM_RD: return 1'b0;
            SQ_SW_WR: return st >= STEP_SELECT;
            SQ_SW_RD: return st == STEP_SELECT;
        endcase
    endfunction

    function automatic logic is_sw(input pcrc_seq_t sq);
        return (sq == SQ_SW_WR) || (sq == SQ_SW_RD);
    endfunction

    pcrc_state_t state_reg, state_next;
    pcrc_seq_t seq_reg, seq_next;
    logic [1:0] step_reg, step_next;
    logic [AW-1:0] op_cfg_reg;
    logic [AW-1:0] op_addr_reg;
    logic [DW-1:0] op_wdata_reg;
    logic [AW-1:0] shadow_reg;
    logic [DW-1:0] rdata_reg;
    logic zz_locked_reg;
    logic asleep_reg;
    logic deep_reg;
    logic ev_reject_reg;
    logic ev_lost_reg;
    logic t_load;
    logic [TIMER_W-1:0] t_count;
    logic t_done;

    pcrc_timer u_timer (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_load(t_load),
        .i_count(t_count),
        .o_done(t_done)
    );

    // Command decode.
    wire idle = state_reg == S_IDLE;
    wire c_pin = ctl.cmd_valid & (ctl.cmd_code == CMD_PIN_LOAD);
    wire c_sw_wr = ctl.cmd_valid & (ctl.cmd_code == CMD_SW_WRITE);
    wire c_sw_rd = ctl.cmd_valid & (ctl.cmd_code == CMD_SW_READ);
    wire c_mem_wr = ctl.cmd_valid & (ctl.cmd_code == CMD_MEM_WRITE);
    wire c_mem_rd = ctl.cmd_valid & (ctl.cmd_code == CMD_MEM_READ);
    wire c_sleep = ctl.cmd_valid & (ctl.cmd_code == CMD_SLEEP);
    wire c_wake = ctl.cmd_valid & (ctl.cmd_code == CMD_WAKE);

    // Reserved bits are forced low before any load.
    wire [AW-1:0] cfg_clean = ctl.cfg & CFG_KEEP_MASK;
    wire temp_too_low = temp_rank(cfg_clean[TEMP_LSB +: 2]) < temp_rank(ctl.temp_floor);
    // The software sequence must neither enter nor leave deep sleep selection.
    wire sw_keeps_par = cfg_clean[SLEEP_BIT] & shadow_reg[SLEEP_BIT];
    // Once locked, a low pin would not start partial refresh, so sleep is refused.
    wire sleep_usable = ~(zz_locked_reg & shadow_reg[SLEEP_BIT]);

    wire go_pin = idle & c_pin & ~temp_too_low;
    wire go_sw_wr = idle & c_sw_wr & ~temp_too_low & sw_keeps_par;
    wire go_sw_rd = idle & c_sw_rd;
    wire go_mem_wr = idle & c_mem_wr;
    wire go_mem_rd = idle & c_mem_rd;
    wire go_sleep = idle & c_sleep & sleep_usable;
    wire go_wake = (state_reg == S_SLEEP) & c_wake;
    wire go_any = go_pin | go_sw_wr | go_sw_rd | go_mem_wr | go_mem_rd | go_sleep | go_wake;
    wire start_seq = go_pin | go_sw_wr | go_sw_rd | go_mem_wr | go_mem_rd;

    // Step bookkeeping.
    wire cur_wr = step_writes(seq_reg, step_reg);
    wire last_step = is_sw(seq_reg) ? (step_reg == STEP_LAST_SW) : 1'b1;
    wire finish = (state_reg == S_HOLD) & last_step;
    wire active = (state_reg == S_SETUP) | (state_reg == S_STROBE) | (state_reg == S_HOLD);

    // Address and data presented in each step.
    wire [AW-1:0] cur_addr = (seq_reg == SQ_PIN) ? op_cfg_reg :
                             is_sw(seq_reg) ? SW_ADDR : op_addr_reg;
    wire [DW-1:0] cur_data = !is_sw(seq_reg) ? op_wdata_reg :
                             (step_reg == STEP_SELECT) ? SW_SELECT_DATA :
                             op_cfg_reg[DW-1:0];

    // Pin values for the next cycle; the pins themselves are flops.
    wire zz_low = (state_reg == S_ZZ_PRE) | (active & (seq_reg == SQ_PIN)) |
                  (state_reg == S_SLEEP);
    wire strobe = state_reg == S_STROBE;

    assign seq_next = go_pin ? SQ_PIN : go_sw_wr ? SQ_SW_WR : go_sw_rd ? SQ_SW_RD :
                      go_mem_wr ? SQ_MEM_WR : go_mem_rd ? SQ_MEM_RD : seq_reg;

    always_comb begin
        state_next = state_reg;
        step_next = step_reg;
        t_load = 1'b0;
        t_count = T_STROBE;
        unique case (state_reg)
            S_IDLE: begin
                step_next = 2'h0;
                if (go_pin) begin
                    state_next = S_ZZ_PRE;
                end else if (start_seq) begin
                    state_next = S_SETUP;
                end else if (go_sleep) begin
                    state_next = S_SLEEP;
                    t_load = 1'b1;
                    t_count = T_SLEEP;
                end
            end
            S_ZZ_PRE: begin
                state_next = S_SETUP;
            end
            S_SETUP: begin
                state_next = S_STROBE;
                t_load = 1'b1;
                t_count = T_STROBE;
            end
            S_STROBE: begin
                if (t_done) state_next = S_HOLD;
            end
            S_HOLD: begin
                if (!last_step) begin
                    state_next = S_SETUP;
                    step_next = step_reg + 2'h1;
                end else if (seq_reg == SQ_PIN) begin
                    state_next = S_ZZ_POST;
                end else begin
                    state_next = S_IDLE;
                end
            end
            S_ZZ_POST: begin
                state_next = S_IDLE;
            end
            S_SLEEP: begin
                if (go_wake) begin
                    if (deep_reg) begin
                        state_next = S_INIT;
                        t_load = 1'b1;
                        t_count = T_INIT;
                    end else begin
                        state_next = S_IDLE;
                    end
                end
            end
            S_INIT: begin
                if (t_done) state_next = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            state_reg <= S_IDLE;
            seq_reg <= SQ_PIN;
            step_reg <= 2'h0;
        end else begin
            state_reg <= state_next;
            seq_reg <= seq_next;
            step_reg <= step_next;
        end
    end

    // Operands are frozen at the start so a register write cannot tear a sequence.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            op_cfg_reg <= CFG_RESET;
            op_addr_reg <= 19'h0_0000;
            op_wdata_reg <= 16'h0000;
        end else if (start_seq) begin
            op_cfg_reg <= cfg_clean;
            op_addr_reg <= ctl.addr;
            op_wdata_reg <= ctl.wdata;
        end
    end

    // Copy of the device word; it changes when the loading write completes.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            shadow_reg <= CFG_RESET;
            zz_locked_reg <= 1'b0;
        end else if (finish & (seq_reg == SQ_PIN)) begin
            shadow_reg <= op_cfg_reg;
        end else if (finish & (seq_reg == SQ_SW_WR)) begin
            shadow_reg <= {shadow_reg[AW-1:DW], op_cfg_reg[DW-1:0]};
            zz_locked_reg <= 1'b1;
        end
    end

    // Read data is sampled after the enable has been low for the full strobe.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            rdata_reg <= 16'h0000;
        end else if (finish & ~cur_wr) begin
            rdata_reg <= i_dq;
        end
    end

    // Sleep tracking and events.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            asleep_reg <= 1'b0;
            deep_reg <= 1'b0;
            ev_reject_reg <= 1'b0;
            ev_lost_reg <= 1'b0;
        end else begin
            if (go_sleep) deep_reg <= ~shadow_reg[SLEEP_BIT];
            asleep_reg <= (state_reg == S_SLEEP) & t_done & ~go_wake;
            ev_lost_reg <= (state_reg == S_SLEEP) & t_done & ~asleep_reg & deep_reg;
            ev_reject_reg <= ctl.cmd_valid & ~go_any;
        end
    end

    // Pin flops.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_sleep_control_pin_n <= 1'b1;
            o_ce_n <= 1'b1;
            o_we_n <= 1'b1;
            o_oe_n <= 1'b1;
            o_byte_n <= 2'h3;
            o_addr <= 19'h0_0000;
            o_dq <= 16'h0000;
            o_dq_oe <= 1'b0;
        end else begin
            o_sleep_control_pin_n <= ~zz_low;
            o_ce_n <= ~strobe;
            o_we_n <= ~(strobe & cur_wr);
            o_oe_n <= ~(strobe & ~cur_wr);
            o_byte_n <= {2{~active}};
            o_addr <= active ? cur_addr : o_addr;
            o_dq <= active ? cur_data : o_dq;
            o_dq_oe <= active & cur_wr;
        end
    end

    assign ctl.busy = ~idle;
    assign ctl.asleep = asleep_reg;
    assign ctl.init_wait = state_reg == S_INIT;
    assign ctl.zz_locked = zz_locked_reg;
    assign ctl.ev_reject = ev_reject_reg;
    assign ctl.ev_data_lost = ev_lost_reg;
    assign ctl.shadow = shadow_reg;
    assign ctl.rdata = rdata_reg;
endmodule
`default_nettype wire

// >>> src/pcrc_pkg.sv
// Constants, register map and command codes of the memory configuration controller.
// Assumes a 20 MHz reference clock and an APB slave with 8-bit byte addresses.
package pcrc_pkg;

    // Timing figures, in ns as printed, and derived cycle counts.
    localparam int CLK_NS = 50;
    localparam int STROBE_NS = 70;
    localparam int ZZ_LOW_NS = 10000;
    localparam int INIT_NS = 150000;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    // The pin must stay low for longer than the figure, hence one more cycle.
    localparam int SLEEP_CYC = ZZ_LOW_NS / CLK_NS + 1;
    localparam int INIT_CYC = (INIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int TIMER_W = 12;

    // Memory side.
    localparam int AW = 19;
    localparam int DW = 16;
    localparam logic [AW-1:0] SW_ADDR = 19'h7_FFFF;
    localparam logic [DW-1:0] SW_SELECT_DATA = 16'h0000;

    // Configuration word layout.
    localparam logic [AW-1:0] CFG_RESET = 19'h0_0070;
    localparam logic [AW-1:0] CFG_KEEP_MASK = 19'h0_00F7;
    localparam int PAGE_BIT = 7;
    localparam int TEMP_LSB = 5;
    localparam int SLEEP_BIT = 4;
    localparam int COVER_LSB = 0;
    localparam logic [2:0] COVER_NONE = 3'h4;
    localparam logic [1:0] TEMP_85 = 2'h3;
    localparam logic [1:0] TEMP_70 = 2'h0;
    localparam logic [1:0] TEMP_45 = 2'h1;
    localparam logic [1:0] TEMP_15 = 2'h2;

    // Register offsets (byte addresses).
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CFG = 8'h04;
    localparam logic [7:0] OFS_ADDR = 8'h08;
    localparam logic [7:0] OFS_WDATA = 8'h0C;
    localparam logic [7:0] OFS_FLOOR = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_SHADOW = 8'h18;
    localparam logic [7:0] OFS_RDATA = 8'h1C;

    // Status register bit positions.
    localparam int ST_BUSY = 0;
    localparam int ST_ASLEEP = 1;
    localparam int ST_INIT = 2;
    localparam int ST_LOCKED = 3;
    localparam int ST_PAGE = 4;
    localparam int ST_COVER_NONE = 5;
    localparam int ST_ERR = 8;
    localparam int ST_LOST = 9;

    // Command codes written to the control register.
    localparam logic [3:0] CMD_PIN_LOAD = 4'h1;
    localparam logic [3:0] CMD_SW_WRITE = 4'h2;
    localparam logic [3:0] CMD_SW_READ = 4'h3;
    localparam logic [3:0] CMD_MEM_WRITE = 4'h4;
    localparam logic [3:0] CMD_MEM_READ = 4'h5;
    localparam logic [3:0] CMD_SLEEP = 4'h6;
    localparam logic [3:0] CMD_WAKE = 4'h7;

    // Orders temperature codes by the ceiling they stand for.
    function automatic logic [1:0] temp_rank(input logic [1:0] code);
        return (code == TEMP_85) ? 2'h3 : (code == TEMP_70) ? 2'h2 :
               (code == TEMP_45) ? 2'h1 : 2'h0;
    endfunction

endpackage

// >>> src/pcrc_ctl_if.sv
// Orders and status passed between the register block and the pin sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface pcrc_ctl_if;
    logic cmd_valid;
    logic [3:0] cmd_code;
    logic [18:0] cfg;
    logic [18:0] addr;
    logic [15:0] wdata;
    logic [1:0] temp_floor;
    logic busy;
    logic asleep;
    logic init_wait;
    logic zz_locked;
    logic ev_reject;
    logic ev_data_lost;
    logic [18:0] shadow;
    logic [15:0] rdata;

    modport regs (
        output cmd_valid, cmd_code, cfg, addr, wdata, temp_floor,
        input busy, asleep, init_wait, zz_locked, ev_reject, ev_data_lost, shadow, rdata
    );
    modport core (
        input cmd_valid, cmd_code, cfg, addr, wdata, temp_floor,
        output busy, asleep, init_wait, zz_locked, ev_reject, ev_data_lost, shadow, rdata
    );
endinterface
`default_nettype wire

// >>> src/pcrc_timer.sv
// Down counter used for strobe widths, sleep entry and wake-up waits.
// Assumes the loader gives the wanted count minus one for a run of that many cycles.
`timescale 1ns/100ps
`default_nettype none
module pcrc_timer
    import pcrc_pkg::*;
(
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // Load and status.
    input wire logic i_load,
    input wire logic [TIMER_W-1:0] i_count,
    output logic o_done
);
    logic [TIMER_W-1:0] cnt_reg;
    logic [TIMER_W-1:0] cnt_next;

    assign o_done = (cnt_reg == '0);
    assign cnt_next = i_load ? i_count : (o_done ? cnt_reg : cnt_reg - 1'b1);

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule
`default_nettype wire

// >>> src/pcrc_apb_regs.sv
// APB slave holding the controller's own order and status registers.
// Assumes a zero-wait slave is acceptable; read data is prepared in the setup cycle.
`timescale 1ns/100ps
`default_nettype none
module pcrc_apb_regs
    import pcrc_pkg::*;
(
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // APB slave.
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Orders to and status from the sequencer.
    pcrc_ctl_if.regs ctl
);
    logic cmd_valid_reg;
    logic [3:0] cmd_code_reg;
    logic [18:0] cfg_reg;
    logic [18:0] addr_reg;
    logic [15:0] wdata_reg;
    logic [1:0] floor_reg;
    logic err_reg;
    logic lost_reg;
    logic [31:0] prdata_reg;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    wire acc = i_psel & i_penable;
    wire wr = acc & i_pwrite;
    wire mapped = hit(i_paddr, OFS_CTRL) | hit(i_paddr, OFS_CFG) | hit(i_paddr, OFS_ADDR) |
                  hit(i_paddr, OFS_WDATA) | hit(i_paddr, OFS_FLOOR) |
                  hit(i_paddr, OFS_STATUS) | hit(i_paddr, OFS_SHADOW) |
                  hit(i_paddr, OFS_RDATA);
    wire clr_err = wr & hit(i_paddr, OFS_STATUS) & i_pwdata[ST_ERR];
    wire clr_lost = wr & hit(i_paddr, OFS_STATUS) & i_pwdata[ST_LOST];

    wire [31:0] status = {22'h00_0000, lost_reg, err_reg, 2'h0,
                          ctl.shadow[COVER_LSB +: 3] == COVER_NONE,
                          ctl.shadow[PAGE_BIT], ctl.zz_locked, ctl.init_wait,
                          ctl.asleep, ctl.busy};
    wire [31:0] rd_mux = hit(i_paddr, OFS_CFG) ? {13'h0000, cfg_reg} :
                         hit(i_paddr, OFS_ADDR) ? {13'h0000, addr_reg} :
                         hit(i_paddr, OFS_WDATA) ? {16'h0000, wdata_reg} :
                         hit(i_paddr, OFS_FLOOR) ? {30'h0000_0000, floor_reg} :
                         hit(i_paddr, OFS_STATUS) ? status :
                         hit(i_paddr, OFS_SHADOW) ? {13'h0000, ctl.shadow} :
                         hit(i_paddr, OFS_RDATA) ? {16'h0000, ctl.rdata} : 32'h0000_0000;

    assign o_pready = 1'b1;
    assign o_pslverr = acc & ~mapped;
    assign o_prdata = prdata_reg;
    assign ctl.cmd_valid = cmd_valid_reg;
    assign ctl.cmd_code = cmd_code_reg;
    assign ctl.cfg = cfg_reg;
    assign ctl.addr = addr_reg;
    assign ctl.wdata = wdata_reg;
    assign ctl.temp_floor = floor_reg;

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            cmd_valid_reg <= 1'b0;
            cmd_code_reg <= 4'h0;
            cfg_reg <= CFG_RESET;
            addr_reg <= 19'h0_0000;
            wdata_reg <= 16'h0000;
            floor_reg <= TEMP_85;
            err_reg <= 1'b0;
            lost_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            cmd_valid_reg <= wr & hit(i_paddr, OFS_CTRL);
            cmd_code_reg <= i_pwdata[3:0];
            if (wr & hit(i_paddr, OFS_CFG)) cfg_reg <= i_pwdata[18:0];
            if (wr & hit(i_paddr, OFS_ADDR)) addr_reg <= i_pwdata[18:0];
            if (wr & hit(i_paddr, OFS_WDATA)) wdata_reg <= i_pwdata[15:0];
            if (wr & hit(i_paddr, OFS_FLOOR)) floor_reg <= i_pwdata[1:0];
            // A new event wins over a clear in the same cycle.
            err_reg <= (err_reg & ~clr_err) | ctl.ev_reject;
            lost_reg <= (lost_reg & ~clr_lost) | ctl.ev_data_lost;
            if (i_psel & ~i_penable) prdata_reg <= rd_mux;
        end
    end
endmodule
`default_nettype wire

// >>> test/pcrc_ctrl_sva.sv
// Checker for the pins and bus of the memory configuration controller.
// Assumes it is bound into pcrc_ctrl and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module pcrc_ctrl_sva
    import pcrc_pkg::*;
(
    // Clock, reset and bus.
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // Memory pins.
    input wire logic o_sleep_control_pin_n,
    input wire logic o_ce_n,
    input wire logic o_we_n,
    input wire logic o_oe_n,
    input wire logic [1:0] o_byte_n,
    input wire logic [AW-1:0] o_addr,
    input wire logic o_dq_oe
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);
    a_ready_held: assert property (o_pready) else $error("pready low");
    a_err_access: assert property (o_pslverr |-> i_psel && i_penable) else $error("stray pslverr");
    a_strobe_two: assert property ($fell(o_ce_n) |-> !o_ce_n ##1 !o_ce_n ##1 o_ce_n)
        else $error("strobe width");
    a_write_drive: assert property (!o_we_n |-> !o_ce_n && o_oe_n && o_dq_oe)
        else $error("write pins");
    a_read_float: assert property (!o_oe_n |-> !o_ce_n && !o_dq_oe) else $error("read pins");
    a_bytes_on: assert property (!o_ce_n |-> o_byte_n == 2'h0) else $error("bytes off");
    a_addr_steady: assert property (!o_ce_n |-> $stable(o_addr)) else $error("addr moved");
    a_reserved_zero: assert property (!o_sleep_control_pin_n && !o_we_n |->
        o_addr[18:8] == 11'h000 && !o_addr[3]) else $error("reserved bit set");
    a_load_release: assert property ($rose(o_ce_n) && !o_sleep_control_pin_n |->
        ##[1:2] o_sleep_control_pin_n) else $error("pin not released");
    a_reset_idle: assert property ($fell(i_srst) |-> o_ce_n && o_sleep_control_pin_n && !o_dq_oe)
        else $error("pins not idle");
    c_write: cover property ($fell(o_ce_n) && !o_we_n);
    c_read: cover property (!o_oe_n);
    c_wake: cover property ($rose(o_sleep_control_pin_n));
endmodule
bind pcrc_ctrl pcrc_ctrl_sva i_sva (.*);
`default_nettype wire

// >>> test/pcrc_mem_model.sv
// Behavioural memory holding the configuration word, sampled on the bench clock.
// Assumes the controller's pins change only after rising edges.
`timescale 1ns/100ps
`default_nettype none
module pcrc_mem_model
    import pcrc_pkg::*;
(
    // Clock and power-up.
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // Pins from the controller.
    input wire logic i_sleep_control_pin_n,
    input wire logic i_ce_n,
    input wire logic i_we_n,
    input wire logic i_oe_n,
    input wire logic [AW-1:0] i_addr,
    input wire logic [DW-1:0] i_dq,
    // Data back and observation.
    output logic [DW-1:0] o_dq,
    output logic [AW-1:0] o_cfg,
    output logic o_deep,
    output logic o_viol
);
    logic [AW-1:0] cfg_reg;
    logic [DW-1:0] last_reg;
    logic ce_q, we_q, oe_q, zz_q, arm_reg, sw_reg, deep_reg, viol_reg;
    logic [2:0] seq_reg;
    int low_reg, init_reg;
    wire rd_act = !i_oe_n || !oe_q;
    // Released lines show the inverse of the last value, so stale data cannot pass.
    assign o_dq = !rd_act ? ~last_reg : (seq_reg == 3'h4) ? cfg_reg[DW-1:0] : 16'hC3A5;
    assign o_cfg = cfg_reg;
    assign o_deep = deep_reg;
    assign o_viol = viol_reg;
    always_ff @(posedge i_ref_clk) begin
        {ce_q, we_q, oe_q, zz_q} <= {i_ce_n, i_we_n, i_oe_n, i_sleep_control_pin_n};
        last_reg <= o_dq;
        low_reg <= i_sleep_control_pin_n ? 0 : low_reg + 1;
        arm_reg <= !i_sleep_control_pin_n && (arm_reg || zz_q);
        if (low_reg == SLEEP_CYC && !cfg_reg[SLEEP_BIT]) deep_reg <= 1'b1;
        if (deep_reg && i_sleep_control_pin_n) begin
            deep_reg <= 1'b0;
            init_reg <= INIT_CYC;
        end else if (init_reg != 0) init_reg <= init_reg - 1;
        if (!i_ce_n && (init_reg != 0 || deep_reg)) viol_reg <= 1'b1;
        if (ce_q && !i_ce_n) seq_reg <= (i_addr != SW_ADDR) ? 3'h0 :
            (seq_reg == 3'h4) ? 3'h1 : seq_reg + 3'h1;
        if (!ce_q && i_ce_n && !we_q) begin
            if (arm_reg) begin
                cfg_reg <= i_addr;
                arm_reg <= 1'b0;
            end else if (seq_reg == 3'h4) begin
                cfg_reg[DW-1:0] <= i_dq;
                sw_reg <= 1'b1;
            end
        end
        if (i_srst) begin
            {arm_reg, sw_reg, deep_reg, viol_reg, seq_reg, low_reg, init_reg} <= '0;
            cfg_reg <= 19'h0_0070;
        end
    end
endmodule
`default_nettype wire

// >>> test/tb_psram_config_register_ctrl.sv
// Self-checking bench for the memory configuration controller.
// Assumes the memory model stands on the pins and the bench masters APB.
`timescale 1ns/100ps
`default_nettype none
module tb_psram_config_register_ctrl;
    import pcrc_pkg::*;
    logic i_ref_clk = 0, i_srst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, serr;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0000_0000, o_prdata, rd, v;
    logic o_pready, o_pslverr, o_sleep_control_pin_n, o_ce_n, o_we_n, o_oe_n, o_dq_oe;
    logic deep, viol;
    logic [1:0] o_byte_n;
    logic [AW-1:0] o_addr, cfg;
    logic [DW-1:0] i_dq, o_dq;
    int errors = 0, compares = 0;
    pcrc_ctrl i_dut (.*);
    pcrc_mem_model i_mem (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
        .i_sleep_control_pin_n(o_sleep_control_pin_n), .i_ce_n(o_ce_n), .i_we_n(o_we_n),
        .i_oe_n(o_oe_n), .i_addr(o_addr), .i_dq(o_dq), .o_dq(i_dq), .o_cfg(cfg),
        .o_deep(deep), .o_viol(viol));
    initial forever #25 i_ref_clk = ~i_ref_clk;
    task automatic conclude();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #3_000_000;
        errors++;
        conclude();
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk) {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, a, d};
        @(posedge i_ref_clk) i_penable <= 1'b1;
        do @(posedge i_ref_clk); while (o_pready !== 1'b1);
        rd = o_prdata;
        serr = o_pslverr;
        {i_psel, i_penable} <= 2'b00;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic cmd(input logic [3:0] c, input int b, input logic x);
        apb(1'b1, OFS_CTRL, {28'h0, c});
        repeat (3) @(posedge i_ref_clk);
        do apb(1'b0, OFS_STATUS, 32'h0); while (rd[b] !== x);
    endtask
    // Reserved bits 18..8 and 3 never reach the memory.
    function automatic logic [31:0] keep(input logic [31:0] x);
        return x & 32'h0000_00F7;
    endfunction
    initial begin
        void'($urandom(32'h08f9_1643));
        repeat (8) @(posedge i_ref_clk);
        i_srst <= 1'b0;
        rdc(OFS_CFG, 32'h0000_0070);
        chk({13'h0, cfg}, 32'h0000_0070);
        apb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0000_0000);
        chk(serr, 1'b1);
        apb(1'b1, OFS_FLOOR, {30'h0, TEMP_15});
        for (int i = 0; i < 5; i++) begin
            v = (i == 0) ? 32'h0007_FFFF : (i == 1) ? 32'h0000_0074 : ($urandom | 32'h10);
            apb(1'b1, OFS_CFG, v);
            cmd(CMD_PIN_LOAD, ST_BUSY, 1'b0);
            rdc(OFS_SHADOW, keep(v));
            chk({13'h0, cfg}, keep(v));
            apb(1'b0, OFS_STATUS, 32'h0);
            chk(rd[ST_PAGE], v[PAGE_BIT]);
            chk(rd[ST_COVER_NONE], v[2:0] == COVER_NONE);
            cmd(CMD_SW_READ, ST_BUSY, 1'b0);
            rdc(OFS_RDATA, keep(v));
        end
        apb(1'b1, OFS_FLOOR, {30'h0, TEMP_85});
        apb(1'b1, OFS_CFG, 32'h0000_0010);
        cmd(CMD_PIN_LOAD, ST_ERR, 1'b1);
        chk({13'h0, cfg}, keep(v));
        apb(1'b1, OFS_STATUS, 32'h0000_0100);
        apb(1'b1, OFS_CFG, 32'h0000_00F4);
        cmd(CMD_SW_WRITE, ST_BUSY, 1'b0);
        chk({13'h0, cfg}, 32'h0000_00F4);
        cmd(CMD_SLEEP, ST_ERR, 1'b1);
        chk(o_sleep_control_pin_n, 1'b1);
        apb(1'b1, OFS_STATUS, 32'h0000_0100);
        apb(1'b1, OFS_CFG, 32'h0000_0060);
        cmd(CMD_PIN_LOAD, ST_BUSY, 1'b0);
        cmd(CMD_SLEEP, ST_ASLEEP, 1'b1);
        repeat (4) @(posedge i_ref_clk);
        chk(deep, 1'b1);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd[ST_LOST], 1'b1);
        cmd(CMD_WAKE, ST_BUSY, 1'b0);
        apb(1'b1, OFS_ADDR, 32'h0001_2345);
        apb(1'b1, OFS_WDATA, $urandom);
        cmd(CMD_MEM_WRITE, ST_BUSY, 1'b0);
        cmd(CMD_MEM_READ, ST_BUSY, 1'b0);
        rdc(OFS_RDATA, 32'h0000_C3A5);
        chk(viol, 1'b0);
        conclude();
    end
endmodule
`default_nettype wire
